// *** src/ast_top.sv ***
`default_nettype none
module ast_top #(
	// Batch length in cycles; shortened only to keep simulations brief
	parameter int BATCH_CYCLES = ast_pkg::BATCH_CYC
) (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic signed [ast_pkg::VAL_W-1:0] reading_in,
	input wire logic signed [ast_pkg::VAL_W-1:0] offset_in,
	input wire logic overrange_in,
	input wire logic underrange_in,
	input wire logic short_in,
	input wire logic [1:0] time_base_select_in,
	input wire logic [2:0] decimal_point_select_in,
	input wire logic [15:0] total_scale_factor_in,
	input wire logic signed [ast_pkg::VAL_W-1:0] low_cutoff_level_in,
	input wire logic total_clear_in,
	input wire logic wr_valid_in,
	input wire logic wr_serial_in,
	input wire logic wr_quick_in,
	input wire logic [1:0] wr_sel_in,
	input wire logic signed [ast_pkg::VAL_W-1:0] wr_data_in,
	input wire logic quick_only_in,
	input wire logic track_in,
	input wire logic alarm_display_en_in,
	input wire logic [1:0] src_total_in,
	input wire logic [1:0] low_act_in,
	input wire logic [1:0] latch_in,
	input wire logic panel_reset_in,
	input wire logic remote_reset_in,
	output logic signed [ast_pkg::VAL_W-1:0] display_out,
	output logic signed [ast_pkg::VAL_W-1:0] total_out,
	output logic signed [ast_pkg::VAL_W-1:0] setpoint1_out,
	output logic signed [ast_pkg::VAL_W-1:0] setpoint2_out,
	output logic [1:0] relay_out,
	output logic [1:0] transistor_out,
	output logic alarm_display_out
);
	// Working width of readings, setpoints and total
	localparam int W = ast_pkg::VAL_W;
	// Sync stages: _m is the first flop, only _s is read by logic
	logic rst_m;
	logic rst_s;
	logic [2:0] fault_m;
	logic [2:0] fault_s;
	logic [1:0] rst_req_m;
	logic [1:0] rst_req_s;
	logic signed [W-1:0] sp [2];
	logic signed [W-1:0] hy [2];
	logic signed [W-1:0] total;
	logic [ast_pkg::BATCH_CW-1:0] batch_cnt;
	// Remainder of the last batch divide, kept so totals do not drift
	logic signed [63:0] frac_acc;
	wire logic [1:0] act;

	// Reset released through two flops
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rst_m <= 1'b0;
			rst_s <= 1'b0;
		end else begin
			rst_m <= 1'b1;
			rst_s <= rst_m;
		end
	end

	// Pin-level status and reset inputs synchronised
	always_ff @(posedge clk_in or negedge rst_s) begin
		if (!rst_s) begin
			fault_m <= 3'h0;
			fault_s <= 3'h0;
			rst_req_m <= 2'h0;
			rst_req_s <= 2'h0;
		end else begin
			fault_m <= {overrange_in, underrange_in, short_in};
			fault_s <= fault_m;
			rst_req_m <= {remote_reset_in, panel_reset_in};
			rst_req_s <= rst_req_m;
		end
	end

	// Any range fault or either reset request, after sync
	wire logic fault = |fault_s;
	wire logic alarm_reset = |rst_req_s;

	// Corrected reading
	wire logic signed [W-1:0] corrected = W'(reading_in + offset_in);

	// Write permission: quick and serial paths always, full path unless locked
	wire logic wr_ok = wr_valid_in && (wr_quick_in || wr_serial_in || !quick_only_in);
	// Tracking delta, taken before the new value lands
	wire logic signed [W-1:0] sp2_delta = W'(wr_data_in - sp[1]);

	// Setpoint and hysteresis store; tracking moves alarm one
	always_ff @(posedge clk_in or negedge rst_s) begin
		if (!rst_s) begin
			sp[0] <= ast_pkg::VAL_ZERO;
			sp[1] <= ast_pkg::VAL_ZERO;
			hy[0] <= ast_pkg::HYST_RST;
			hy[1] <= ast_pkg::HYST_RST;
		end else if (wr_ok) begin
			case (wr_sel_in)
				2'h0: sp[0] <= wr_data_in;
				2'h1: begin
					sp[1] <= wr_data_in;
					if (track_in) begin
						sp[0] <= W'(sp[0] + sp2_delta);
					end
				end
				2'h2: hy[0] <= wr_data_in;
				default: hy[1] <= wr_data_in;
			endcase
		end
	end

	// Time base weight
	// Unused code three falls back to the per-second weight
	wire logic [11:0] tb_w = (time_base_select_in == ast_pkg::TB_MIN) ? ast_pkg::TBW_MIN :
		(time_base_select_in == ast_pkg::TB_HR) ? ast_pkg::TBW_HR : ast_pkg::TBW_SEC;
	// Decimal point weight
	wire logic [13:0] dp_w = (decimal_point_select_in == 3'h1) ? ast_pkg::DPW_1 :
		(decimal_point_select_in == 3'h2) ? ast_pkg::DPW_2 :
		(decimal_point_select_in == 3'h3) ? ast_pkg::DPW_3 :
		(decimal_point_select_in == 3'h4) ? ast_pkg::DPW_4 : ast_pkg::DPW_0;

	// Batch tick every 400 ms
	wire logic batch_tick = (batch_cnt == ast_pkg::BATCH_CW'(BATCH_CYCLES - 1));

	// Scaled batch, reading in tenths, scale factor in thousandths.
	// Numerator and denominator kept exact; remainder carried so no drift.
	wire logic signed [63:0] num = 64'(corrected) * $signed({1'b0, total_scale_factor_in}) *
		$signed({1'b0, dp_w}) * 64'sd2;
	wire logic signed [63:0] den = 64'(tb_w) * 64'sd10 * 64'sd1000 * 64'(ast_pkg::BATCH_PER_SEC_X2);
	wire logic signed [63:0] acc_sum = frac_acc + num;
	// Wide divide is costly in area; traded for exact batch totals
	wire logic signed [63:0] step = acc_sum / den;
	wire logic signed [63:0] new_tot = 64'(total) + step;
	// Cutoff gate works on the corrected value, not the raw one
	wire logic below_cut = corrected < low_cutoff_level_in;
	// Signed bound, so a negative total is not taken as huge
	wire logic signed [63:0] tot_max = $signed(64'(ast_pkg::TOTAL_MAX));
	wire logic signed [W-1:0] clamped = (new_tot > tot_max) ? W'(ast_pkg::TOTAL_MAX) :
		(new_tot < -tot_max) ? -W'(ast_pkg::TOTAL_MAX) : W'(new_tot);

	// Totalizer: clear wins, then batch unless below cutoff
	always_ff @(posedge clk_in or negedge rst_s) begin
		if (!rst_s) begin
			batch_cnt <= '0;
			total <= ast_pkg::VAL_ZERO;
			frac_acc <= 64'sd0;
		end else begin
			// Free-running, so a clear does not restart the interval
			batch_cnt <= batch_tick ? '0 : batch_cnt + 1'b1;
			if (total_clear_in) begin
				total <= ast_pkg::VAL_ZERO;
				frac_acc <= 64'sd0;
			end else if (batch_tick && !below_cut) begin
				total <= clamped;
				frac_acc <= acc_sum - step * den;
			end
		end
	end

	// Two alarm instances, each with own source
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : gen_alarm
			ast_alarm u_alarm (
				.clk_in(clk_in),
				.rst_b_in(rst_s),
				.value_in(src_total_in[g] ? total : corrected),
				.setpoint_in(sp[g]),
				.hyst_in(hy[g]),
				.low_act_in(low_act_in[g]),
				.latch_in(latch_in[g]),
				.reset_in(alarm_reset),
				.fault_in(fault),
				.active_out(act[g])
			);
		end
	endgenerate

	// Registered outputs; relay and transistor share one source
	always_ff @(posedge clk_in or negedge rst_s) begin
		if (!rst_s) begin
			display_out <= ast_pkg::VAL_ZERO;
			total_out <= ast_pkg::VAL_ZERO;
			setpoint1_out <= ast_pkg::VAL_ZERO;
			setpoint2_out <= ast_pkg::VAL_ZERO;
			relay_out <= 2'h0;
			transistor_out <= 2'h0;
			alarm_display_out <= 1'b0;
		end else begin
			display_out <= corrected;
			total_out <= total;
			setpoint1_out <= sp[0];
			setpoint2_out <= sp[1];
			relay_out <= fault ? 2'h0 : act;
			transistor_out <= fault ? 2'h0 : act;
			alarm_display_out <= alarm_display_en_in && |act && !fault;
		end
	end
endmodule
`default_nettype wire

// *** src/ast_pkg.sv ***
`default_nettype none
package ast_pkg;
	// Reading and total width, signed tenths
	localparam int VAL_W = 24;
	localparam int CLK_HZ = 20_000_000;
	// Totalizer update interval
	localparam int BATCH_MS = 400;
	localparam int BATCH_CYC = CLK_HZ / 1000 * BATCH_MS;
	localparam int BATCH_CW = 24;
	// Time base select codes and weights
	localparam logic [1:0] TB_SEC = 2'h0;
	localparam logic [1:0] TB_MIN = 2'h1;
	localparam logic [1:0] TB_HR = 2'h2;
	localparam logic [11:0] TBW_SEC = 12'h001;
	localparam logic [11:0] TBW_MIN = 12'h03c;
	localparam logic [11:0] TBW_HR = 12'he10;
	// Decimal point weights, 0 to 4 fractional digits
	localparam logic [13:0] DPW_0 = 14'h0001;
	localparam logic [13:0] DPW_1 = 14'h000a;
	localparam logic [13:0] DPW_2 = 14'h0064;
	localparam logic [13:0] DPW_3 = 14'h03e8;
	localparam logic [13:0] DPW_4 = 14'h2710;
	// Batches per time base unit: 2.5 per second
	localparam int BATCH_PER_SEC_X2 = 5;
	// Capacity 99999.9 in tenths
	localparam logic [23:0] TOTAL_MAX = 24'h0f423f;
	localparam logic [VAL_W-1:0] VAL_ZERO = '0;
	// Hysteresis after reset, 0.1 degree
	localparam logic signed [VAL_W-1:0] HYST_RST = 24'sh000001;
	// Alarm state encoding
	typedef enum logic [1:0] {
		AST_OFF = 2'b01,
		AST_ON = 2'b10
	} ast_alarm_st_t;
endpackage
`default_nettype wire

// *** src/ast_alarm.sv ***
`default_nettype none
// One setpoint alarm with hysteresis, sense and latch
module ast_alarm (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic signed [ast_pkg::VAL_W-1:0] value_in,
	input wire logic signed [ast_pkg::VAL_W-1:0] setpoint_in,
	input wire logic signed [ast_pkg::VAL_W-1:0] hyst_in,
	input wire logic low_act_in,
	input wire logic latch_in,
	input wire logic reset_in,
	input wire logic fault_in,
	output logic active_out
);
	ast_pkg::ast_alarm_st_t st;
	ast_pkg::ast_alarm_st_t next_st;
	wire logic trip;
	wire logic release_ok;

	// Trip and release thresholds per sense
	assign trip = low_act_in ? (value_in <= setpoint_in) : (value_in >= setpoint_in);
	assign release_ok = low_act_in ? (value_in > setpoint_in + hyst_in) : (value_in < setpoint_in - hyst_in);

	// Latched alarm holds until reset; fault forces off
	always_comb begin
		next_st = st;
		case (st)
			ast_pkg::AST_OFF: begin
				if (trip) begin
					next_st = ast_pkg::AST_ON;
				end
			end
			ast_pkg::AST_ON: begin
				if (latch_in ? reset_in : release_ok) begin
					next_st = ast_pkg::AST_OFF;
				end
			end
			default: next_st = ast_pkg::AST_OFF;
		endcase
		if (fault_in) begin
			next_st = ast_pkg::AST_OFF;
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			st <= ast_pkg::AST_OFF;
		end else begin
			st <= next_st;
		end
	end

	assign active_out = (st == ast_pkg::AST_ON);
endmodule
`default_nettype wire

// *** test/ast_props.sv ***
`default_nettype none
// Port-level checks on the alarm and totalizer top
module ast_props (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic signed [ast_pkg::VAL_W-1:0] reading_in,
	input wire logic signed [ast_pkg::VAL_W-1:0] offset_in,
	input wire logic overrange_in,
	input wire logic underrange_in,
	input wire logic short_in,
	input wire logic total_clear_in,
	input wire logic wr_valid_in,
	input wire logic wr_serial_in,
	input wire logic [1:0] wr_sel_in,
	input wire logic signed [ast_pkg::VAL_W-1:0] wr_data_in,
	input wire logic track_in,
	input wire logic alarm_display_en_in,
	input wire logic [1:0] latch_in,
	input wire logic panel_reset_in,
	input wire logic remote_reset_in,
	input wire logic signed [ast_pkg::VAL_W-1:0] display_out,
	input wire logic signed [ast_pkg::VAL_W-1:0] total_out,
	input wire logic signed [ast_pkg::VAL_W-1:0] setpoint1_out,
	input wire logic signed [ast_pkg::VAL_W-1:0] setpoint2_out,
	input wire logic [1:0] relay_out,
	input wire logic [1:0] transistor_out,
	input wire logic alarm_display_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);
	// Any range fault, raw at the pins
	wire logic fault = overrange_in | underrange_in | short_in;
	a_out_mirror: assert property (relay_out == transistor_out)
		else $error("transistor and relay differ");
	a_display_sum: assert property ($past(rst_b_in, 4) |-> display_out == $past(reading_in) + $past(offset_in))
		else $error("display not reading plus offset");
	a_fault_drop: assert property (fault [*6] |-> relay_out == 2'h0)
		else $error("relay held during range fault");
	// Resets and faults pass two sync flops, hence the long quiet window
	a_latch_hold: assert property ((latch_in[0] && !panel_reset_in && !remote_reset_in && !fault) [*4] ##0 relay_out[0]
		|=> relay_out[0])
		else $error("latched alarm dropped");
	a_total_clear: assert property (total_clear_in [*3] |-> total_out == '0)
		else $error("total not cleared");
	a_disp_off: assert property (!alarm_display_en_in [*3] |-> !alarm_display_out)
		else $error("alarm display while disabled");
	a_disp_on: assert property ((alarm_display_en_in && relay_out != 2'h0) [*3] |-> alarm_display_out)
		else $error("alarm display missing");
	a_sp_write: assert property (wr_valid_in && wr_serial_in && wr_sel_in == 2'h1 ##1 !wr_valid_in
		|=> setpoint2_out == $past(wr_data_in, 2))
		else $error("second setpoint not written");
	a_track_gap: assert property (!$past(wr_valid_in) && wr_valid_in && wr_serial_in && track_in && wr_sel_in == 2'h1
		##1 !wr_valid_in |=> setpoint2_out - setpoint1_out == $past(setpoint2_out, 2) - $past(setpoint1_out, 2))
		else $error("tracking gap changed");
endmodule
`default_nettype wire

// *** test/ast_front.sv ***
`default_nettype none
// Front end model: reading and range flags
module ast_front (
	input wire logic clk_in,
	input wire logic signed [ast_pkg::VAL_W-1:0] level_in,
	input wire logic [2:0] fault_in,
	output logic signed [ast_pkg::VAL_W-1:0] reading_out,
	output logic over_out,
	output logic under_out,
	output logic short_out
);
	timeunit 1ns;
	timeprecision 1ns;
	initial {reading_out, short_out, under_out, over_out} = '0;
	// Result lands one cycle late, away from the sampling edge
	always @(negedge clk_in) begin
		reading_out <= level_in;
		{short_out, under_out, over_out} <= fault_in;
	end
endmodule
`default_nettype wire

// *** test/test_ast_top.sv ***
`default_nettype none
module test_ast_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int W = ast_pkg::VAL_W;
	// Short batch interval so several batches fit in one run
	localparam int BATCH = 64;
	logic clk_in = '0, rst_b_in = '0, total_clear_in = '0, wr_valid_in = '0, wr_serial_in = '0, wr_quick_in = '0;
	logic quick_only_in = '0, track_in = '0, alarm_display_en_in = '0, panel_reset_in = '0, remote_reset_in = '0;
	logic [1:0] time_base_select_in = '0, wr_sel_in = '0, src_total_in = '0, low_act_in = '0, latch_in = '0;
	logic [2:0] decimal_point_select_in = '0, fault = '0;
	logic [15:0] total_scale_factor_in = 16'h03e8;
	logic signed [W-1:0] offset_in = '0, low_cutoff_level_in = '0, wr_data_in = '0, level = '0;
	wire logic signed [W-1:0] reading_in, display_out, total_out, setpoint1_out, setpoint2_out;
	wire logic overrange_in, underrange_in, short_in, alarm_display_out;
	wire logic [1:0] relay_out, transistor_out;
	int n_fail = 0, comparisons = 0, cyc = 0;
	ast_top #(.BATCH_CYCLES(BATCH)) DUT (.*);
	ast_front FE (.clk_in, .level_in(level), .fault_in(fault), .reading_out(reading_in), .over_out(overrange_in),
		.under_out(underrange_in), .short_out(short_in));
	always #25 clk_in = ~clk_in;
	// Hang guard, far above the few thousand cycles needed
	always @(posedge clk_in) if (++cyc == 20000) begin
		n_fail++;
		report_and_stop();
	end
	task automatic chk(input logic [W-1:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: saw %0h want %0h", $time, seen, exp);
		end
	endtask
	task automatic w(input int n);
		repeat (n) @(negedge clk_in);
	endtask
	// Reading path is model, display, alarm, relay: allow eight cycles
	task automatic lv(input logic signed [W-1:0] v);
		level = v;
		w(8);
	endtask
	task automatic wr(input logic [1:0] sel, input logic signed [W-1:0] d, input logic ser, qk);
		{wr_valid_in, wr_sel_in, wr_data_in, wr_serial_in, wr_quick_in} = {1'h1, sel, d, ser, qk};
		w(1);
		wr_valid_in = 1'h0;
		w(3);
	endtask
	// Clear, wait for the first batch, then two more batches
	task automatic tot(input logic [1:0] tb, input logic [2:0] dp, input logic [W-1:0] first, third);
		{time_base_select_in, decimal_point_select_in} = {tb, dp};
		total_clear_in = 1'h1;
		w(2);
		total_clear_in = 1'h0;
		for (int i = 0; i < 2 * BATCH && total_out == '0; i++) w(1);
		chk(total_out, first);
		w(2 * BATCH + BATCH / 2);
		chk(total_out, third);
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		w(2);
		rst_b_in = 1'h1;
		w(3);
		offset_in = -24'sh000064;
		lv(24'sh0000fa);
		chk(display_out, 24'h000096);
		offset_in = 24'sh000064;
		lv(24'sh0000fa);
		chk(display_out, 24'h00015e);
		offset_in = '0;
		$display("offset test done");
		wr(2'h0, 24'sh000032, 1'h1, 1'h0);
		wr(2'h1, 24'sh000064, 1'h1, 1'h0);
		chk(setpoint1_out, 24'h000032);
		track_in = 1'h1;
		wr(2'h1, 24'sh000096, 1'h1, 1'h0);
		chk(setpoint1_out, 24'h000064);
		chk(setpoint2_out, 24'h000096);
		track_in = 1'h0;
		quick_only_in = 1'h1;
		wr(2'h1, 24'sh0001f4, 1'h0, 1'h0);
		chk(setpoint2_out, 24'h000096);
		wr(2'h1, 24'sh000190, 1'h0, 1'h1);
		chk(setpoint2_out, 24'h000190);
		quick_only_in = 1'h0;
		wr(2'h1, 24'sh0001f4, 1'h0, 1'h0);
		chk(setpoint2_out, 24'h0001f4);
		wr(2'h1, 24'sh000190, 1'h0, 1'h0);
		$display("setpoint test done");
		lv(24'sh000064);
		chk(relay_out, 2'h1);
		lv(24'sh000063);
		chk(relay_out, 2'h1);
		lv(24'sh000062);
		chk(relay_out, 2'h0);
		low_act_in = 2'h2;
		w(8);
		chk(relay_out, 2'h2);
		wr(2'h3, 24'sh000032, 1'h1, 1'h0);
		lv(24'sh0001c2);
		chk(relay_out, 2'h3);
		lv(24'sh0001c3);
		chk(relay_out, 2'h1);
		total_clear_in = 1'h1;
		w(3);
		total_clear_in = 1'h0;
		chk(total_out, '0);
		src_total_in = 2'h2;
		w(8);
		chk(relay_out, 2'h3);
		src_total_in = 2'h0;
		$display("alarm test done");
		// 10.0 degrees at scale 1.000: 4 counts a batch per second at no fraction
		lv(24'sh000064);
		tot(2'h0, 3'h0, 24'h000004, 24'h00000c);
		tot(2'h0, 3'h1, 24'h000028, 24'h000078);
		tot(2'h0, 3'h2, 24'h000190, 24'h0004b0);
		tot(2'h0, 3'h3, 24'h000fa0, 24'h002ee0);
		tot(2'h0, 3'h4, 24'h009c40, 24'h01d4c0);
		tot(2'h1, 3'h4, 24'h00029a, 24'h0007d0);
		tot(2'h2, 3'h4, 24'h00000b, 24'h000021);
		total_scale_factor_in = 16'hffff;
		tot(2'h0, 3'h4, 24'h0f423f, 24'h0f423f);
		total_scale_factor_in = 16'h03e8;
		low_cutoff_level_in = 24'sh0000c8;
		tot(2'h0, 3'h1, '0, '0);
		low_cutoff_level_in = -24'sh0000c8;
		lv(-24'sh000064);
		tot(2'h0, 3'h1, 24'hffffd8, 24'hffff88);
		low_cutoff_level_in = '0;
		$display("totalizer test done");
		latch_in = 2'h1;
		for (int i = 0; i < 2; i++) begin
			lv(24'sh000064);
			lv('0);
			chk(relay_out[0], 1'h1);
			{remote_reset_in, panel_reset_in} = 2'h1 << i;
			w(4);
			{remote_reset_in, panel_reset_in} = 2'h0;
			w(6);
			chk(relay_out[0], 1'h0);
		end
		lv(24'sh000064);
		for (int i = 0; i < 3; i++) begin
			fault = 3'h1 << i;
			w(8);
			chk(relay_out, 2'h0);
			chk(transistor_out, 2'h0);
			fault = '0;
			w(8);
			chk(relay_out, 2'h3);
			chk(transistor_out, 2'h3);
		end
		alarm_display_en_in = 1'h1;
		w(4);
		chk(alarm_display_out, 1'h1);
		alarm_display_en_in = 1'h0;
		w(4);
		chk(alarm_display_out, 1'h0);
		$display("latch and fault test done");
		report_and_stop();
	end
endmodule
bind ast_top ast_props chk_i (.*);
`default_nettype wire
